// ==== core/sdci_core.sv ====
// Card-side initialization, identification and operation conditions logic.
`timescale 1ns/100ps
module sdci_core #(
	parameter bit HIGH_CAP = 1'b1,
	parameter bit DUAL_VOLT = 1'b1,
	parameter int POWERUP_US = 100,
	// Identity and specific data values are arbitrary.
	parameter logic [127:0] CID_VALUE = 128'h0000_0000_0000_0000_0000_0000_0000_0001,
	parameter logic [127:0] CSD_VALUE = 128'h0000_0000_0000_0000_0000_0000_0000_0001,
	parameter logic [63:0] SCR_VALUE = 64'h0000_0000_0000_0000
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link clock and command line
	input wire logic sd_clk,
	input wire logic cmd_in,
	output logic cmd_out,
	output logic cmd_oe,
	// Card status in the system clock domain
	output logic init_ready,
	output logic ident_done,
	output logic inactive
);

	localparam int POWERUP_CYC = POWERUP_US * sdci_pkg::CLK_MHZ;

	// ************************************************************
	// Helper functions.
	// ************************************************************

	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:0], 1'b0} ^ (fb ? sdci_pkg::CRC_POLY : 7'h00);
		end
		return c;
	endfunction

	function automatic logic [47:0] resp48(input logic [5:0] idx, input logic [31:0] body);
		return {2'b00, idx, body, crc7({2'b00, idx, body}), 1'b1};
	endfunction

	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {1'b0, s[15:1]} ^ (s[0] ? sdci_pkg::LFSR_TAPS : 16'h0000);
	endfunction

	// ************************************************************
	// Link domain synchronisers.
	// ************************************************************

	logic rst_m, rst_s, cmd_m, cmd_s, pd_m, pd_s;
	logic done;

	always_ff @(posedge sd_clk) begin
		rst_m <= rst;
		rst_s <= rst_m;
		cmd_m <= cmd_in;
		cmd_s <= cmd_m;
		pd_m <= done;
		pd_s <= pd_m;
	end

	// ************************************************************
	// Link domain command interpreter.
	// ************************************************************

	sdci_pkg::sdci_state_type state, next_state;
	logic first_done, next_first_done, cmd8_seen, next_cmd8_seen;
	logic busy_forever, next_busy_forever, started, next_started;
	logic app, next_app;
	logic [15:0] rca, next_rca, dsr, next_dsr, lfsr, next_lfsr;
	logic [5:0] rx_cnt, next_rx_cnt;
	logic [46:0] rx_sh, next_rx_sh;
	logic [135:0] tx_sh, next_tx_sh;
	logic [7:0] tx_left, next_tx_left;
	logic [1:0] tx_wait, next_tx_wait;
	logic next_cmd_out, next_cmd_oe;
	logic lvl_ready, lvl_stby, lvl_inact;
	logic [47:0] frame;
	logic [5:0] idx;
	logic [31:0] arg, cond_word, stat;
	logic take, cond_ready;
	logic [15:0] cand;
	logic [15:0] dsr_arg;

	localparam int WIN_HI = sdci_pkg::COND_WIN_HI;
	localparam int WIN_LO = sdci_pkg::COND_WIN_LO;
	localparam int STAT_HI = sdci_pkg::STAT_STATE + 3;

	assign dsr_arg = arg[31:16];

	always_comb begin
		// Bit 31 rises only after the first ACMD41 and the power-up delay.
		cond_ready = first_done & pd_s & ~busy_forever;
		cond_word = 32'h0000_0000;
		cond_word[WIN_HI:WIN_LO] = sdci_pkg::COND_WINDOW;
		cond_word[sdci_pkg::COND_BUSY] = cond_ready;
		cond_word[sdci_pkg::COND_CCS] = cond_ready & cmd8_seen & HIGH_CAP;
		cond_word[sdci_pkg::COND_DUAL] = DUAL_VOLT & cmd8_seen;
		frame = {rx_sh, cmd_s};
		idx = frame[45:40];
		arg = frame[39:8];
		take = (rx_cnt == sdci_pkg::FRAME_LAST) && frame[46] && frame[0]
			&& (crc7(frame[47:8]) == frame[7:1]);
		cand = (lfsr == rca) ? lfsr_step(lfsr) : lfsr;
		stat = 32'h0000_0000;
		case (state)
			sdci_pkg::ST_READY: stat[STAT_HI:sdci_pkg::STAT_STATE] = 4'h1;
			sdci_pkg::ST_IDENT: stat[STAT_HI:sdci_pkg::STAT_STATE] = 4'h2;
			sdci_pkg::ST_STBY: stat[STAT_HI:sdci_pkg::STAT_STATE] = 4'h3;
			default: stat[STAT_HI:sdci_pkg::STAT_STATE] = 4'h0;
		endcase
		next_state = state;
		next_first_done = first_done;
		next_cmd8_seen = cmd8_seen;
		next_busy_forever = busy_forever;
		next_started = started;
		next_app = app;
		next_rca = rca;
		next_dsr = dsr;
		next_lfsr = lfsr_step(lfsr);
		next_rx_cnt = rx_cnt;
		next_rx_sh = rx_sh;
		next_tx_sh = tx_sh;
		next_tx_left = tx_left;
		next_tx_wait = tx_wait;
		next_cmd_out = 1'b1;
		next_cmd_oe = 1'b0;
		if (tx_wait != 2'h0) begin
			next_tx_wait = tx_wait - 2'h1;
		end else if (tx_left != 8'h00) begin
			next_cmd_out = tx_sh[135];
			next_cmd_oe = 1'b1;
			next_tx_sh = {tx_sh[134:0], 1'b0};
			next_tx_left = tx_left - 8'h01;
			// Blank the synchroniser so the card's own reply is not read as a command.
			if (tx_left == 8'h01) begin
				next_tx_wait = sdci_pkg::NCR_WAIT;
			end
		end else if (rx_cnt != 6'h00 || !cmd_s) begin
			next_rx_sh = {rx_sh[45:0], cmd_s};
			next_rx_cnt = rx_cnt + 6'h01;
			if (rx_cnt == sdci_pkg::FRAME_LAST) begin
				next_rx_cnt = 6'h00;
			end
		end
		// Only decoded commands touch the registers; nothing else reaches them.
		if (take && state != sdci_pkg::ST_INACT) begin
			next_app = 1'b0;
			next_tx_wait = sdci_pkg::NCR_WAIT;
			next_tx_left = 8'h00;
			if (idx == sdci_pkg::CMD_GO_IDLE) begin
				next_state = sdci_pkg::ST_IDLE;
				next_first_done = 1'b0;
				next_cmd8_seen = 1'b0;
				next_busy_forever = 1'b0;
				next_started = 1'b0;
				next_rca = sdci_pkg::RCA_RESET;
			end else if (idx == sdci_pkg::CMD_APP) begin
				next_app = 1'b1;
				stat[sdci_pkg::STAT_APP] = 1'b1;
				next_tx_sh = {resp48(idx, stat), 88'h0};
				next_tx_left = sdci_pkg::LEN_SHORT;
			end else if (idx == sdci_pkg::CMD_IF_COND && state == sdci_pkg::ST_IDLE) begin
				if (arg[11:8] == sdci_pkg::VHS_OK) begin
					next_cmd8_seen = 1'b1;
					next_tx_sh = {resp48(idx, {20'h00000, arg[11:0]}), 88'h0};
					next_tx_left = sdci_pkg::LEN_SHORT;
				end
			end else if (idx == sdci_pkg::ACMD_OP_COND && app && state == sdci_pkg::ST_IDLE) begin
				if (!first_done) begin
					if ((arg[WIN_HI:WIN_LO] & sdci_pkg::COND_WINDOW) == 9'h000) begin
						next_state = sdci_pkg::ST_INACT;
					end else begin
						next_first_done = 1'b1;
						next_started = 1'b1;
						// HCS counts only after CMD8 and only for high capacity.
						next_busy_forever = HIGH_CAP & cmd8_seen & ~arg[sdci_pkg::ARG_HCS];
					end
				end else if (cond_ready) begin
					next_state = sdci_pkg::ST_READY;
				end
				if (next_state != sdci_pkg::ST_INACT) begin
					next_tx_sh = {2'b00, sdci_pkg::IDX_ALL_ONES, cond_word,
						sdci_pkg::CRC_NONE, 1'b1, 88'h0};
					next_tx_left = sdci_pkg::LEN_SHORT;
				end
			end else if (idx == sdci_pkg::CMD_ALL_CID && state == sdci_pkg::ST_READY) begin
				next_state = sdci_pkg::ST_IDENT;
				next_tx_sh = {2'b00, sdci_pkg::IDX_ALL_ONES, CID_VALUE[127:1], 1'b1};
				next_tx_left = sdci_pkg::LEN_LONG;
			end else if (idx == sdci_pkg::CMD_SET_RCA
				&& (state == sdci_pkg::ST_IDENT || state == sdci_pkg::ST_STBY)) begin
				next_state = sdci_pkg::ST_STBY;
				next_rca = cand;
				next_tx_sh = {resp48(idx, {cand, stat[23:22], stat[19], stat[12:0]}), 88'h0};
				next_tx_left = sdci_pkg::LEN_SHORT;
			end else if (idx == sdci_pkg::CMD_SEND_CSD && state == sdci_pkg::ST_STBY
				&& arg[31:16] == rca) begin
				next_tx_sh = {2'b00, sdci_pkg::IDX_ALL_ONES, CSD_VALUE[127:1], 1'b1};
				next_tx_left = sdci_pkg::LEN_LONG;
			end else if (idx == sdci_pkg::CMD_SET_DSR && state == sdci_pkg::ST_STBY) begin
				next_dsr = arg[31:16];
			end
		end
	end

	always_ff @(posedge sd_clk) begin
		if (rst_s) begin
			state <= sdci_pkg::ST_IDLE;
			first_done <= 1'b0;
			cmd8_seen <= 1'b0;
			busy_forever <= 1'b0;
			started <= 1'b0;
			app <= 1'b0;
			rca <= sdci_pkg::RCA_RESET;
			dsr <= sdci_pkg::DSR_RESET;
			lfsr <= sdci_pkg::LFSR_SEED;
			rx_cnt <= 6'h00;
			rx_sh <= 47'h0;
			tx_sh <= 136'h0;
			tx_left <= 8'h00;
			tx_wait <= 2'h0;
			cmd_out <= 1'b1;
			cmd_oe <= 1'b0;
			lvl_ready <= 1'b0;
			lvl_stby <= 1'b0;
			lvl_inact <= 1'b0;
		end else begin
			state <= next_state;
			first_done <= next_first_done;
			cmd8_seen <= next_cmd8_seen;
			busy_forever <= next_busy_forever;
			started <= next_started;
			app <= next_app;
			rca <= next_rca;
			dsr <= next_dsr;
			lfsr <= next_lfsr;
			rx_cnt <= next_rx_cnt;
			rx_sh <= next_rx_sh;
			tx_sh <= next_tx_sh;
			tx_left <= next_tx_left;
			tx_wait <= next_tx_wait;
			cmd_out <= next_cmd_out;
			cmd_oe <= next_cmd_oe;
			lvl_ready <= next_state != sdci_pkg::ST_IDLE && next_state != sdci_pkg::ST_INACT;
			lvl_stby <= next_state == sdci_pkg::ST_STBY;
			lvl_inact <= next_state == sdci_pkg::ST_INACT;
		end
	end

	// ************************************************************
	// System domain power-up timer and status crossing.
	// ************************************************************

	logic st_m, st_s, next_done;
	logic rdy_m, stb_m, ina_m;
	logic [23:0] timer, next_timer;

	always_comb begin
		next_timer = 24'h000000;
		next_done = 1'b0;
		if (st_s) begin
			next_done = done;
			next_timer = timer;
			if (timer == 24'(POWERUP_CYC - 1)) begin
				next_done = 1'b1;
			end else begin
				next_timer = timer + 24'h000001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_m <= 1'b0;
			st_s <= 1'b0;
			timer <= 24'h000000;
			done <= 1'b0;
			rdy_m <= 1'b0;
			stb_m <= 1'b0;
			ina_m <= 1'b0;
			init_ready <= 1'b0;
			ident_done <= 1'b0;
			inactive <= 1'b0;
		end else begin
			st_m <= started;
			st_s <= st_m;
			timer <= next_timer;
			done <= next_done;
			rdy_m <= lvl_ready;
			stb_m <= lvl_stby;
			ina_m <= lvl_inact;
			init_ready <= rdy_m;
			ident_done <= stb_m;
			inactive <= ina_m;
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************

	AST_HC_BUSY: assert property (@(posedge sd_clk) disable iff (rst_s)
		busy_forever |-> !cond_word[sdci_pkg::COND_BUSY]) else $error("busy card reported ready");
	AST_HCS_IGNORED: assert property (@(posedge sd_clk) disable iff (rst_s)
		!cmd8_seen || !HIGH_CAP |-> !busy_forever) else $error("HCS used without CMD8");
	AST_CCS_VALID: assert property (@(posedge sd_clk) disable iff (rst_s)
		cond_word[sdci_pkg::COND_CCS] |-> cond_word[sdci_pkg::COND_BUSY] && cmd8_seen)
		else $error("capacity bit before ready");
	AST_WINDOW: assert property (@(posedge sd_clk) disable iff (rst_s)
		cond_word[WIN_HI:WIN_LO] == sdci_pkg::COND_WINDOW && cond_word[29:24] == 6'h00
		&& cond_word[14:8] == 7'h00 && cond_word[6:0] == 7'h00)
		else $error("bad voltage window");
	AST_DUAL: assert property (@(posedge sd_clk) disable iff (rst_s)
		cond_word[sdci_pkg::COND_DUAL] |-> cmd8_seen) else $error("bit 7 set before CMD8");
	AST_FIRST_ONLY: assert property (@(posedge sd_clk) disable iff (rst_s)
		take && idx == sdci_pkg::ACMD_OP_COND && first_done && idx != sdci_pkg::CMD_GO_IDLE
		|=> $stable(busy_forever)) else $error("repeat ACMD41 changed HCS result");
	AST_CID_IDENT: assert property (@(posedge sd_clk) disable iff (rst_s)
		take && idx == sdci_pkg::CMD_ALL_CID && state == sdci_pkg::ST_READY
		|=> state == sdci_pkg::ST_IDENT ##3 cmd_oe [*8]) else $error("CMD2 not answered");
	AST_NEW_RCA: assert property (@(posedge sd_clk) disable iff (rst_s)
		take && idx == sdci_pkg::CMD_SET_RCA && state inside {sdci_pkg::ST_IDENT, sdci_pkg::ST_STBY}
		|=> state == sdci_pkg::ST_STBY && rca != $past(rca) && rca != 16'h0000)
		else $error("CMD3 did not publish a new address");
	AST_INACT_STAYS: assert property (@(posedge sd_clk) disable iff (rst_s)
		state == sdci_pkg::ST_INACT |=> state == sdci_pkg::ST_INACT [*2])
		else $error("left inactive state");
	AST_RCA_RESET: assert property (@(posedge sd_clk)
		rst_s |=> rca == 16'h0000) else $error("address not cleared by reset");
	AST_DSR_SET: assert property (@(posedge sd_clk) disable iff (rst_s)
		take && idx == sdci_pkg::CMD_SET_DSR && state == sdci_pkg::ST_STBY
		|=> dsr == $past(dsr_arg)) else $error("driver stage not written");

endmodule

// ==== core/sdci_pkg.sv ====
// Constants for the card initialization and identification logic.
// Behaviour
// - HCS 1 means host supports high capacity; 0 means it does not.
// - HCS is ignored unless CMD8 was answered; standard capacity always ignores it.
// - High capacity card seeing HCS 0 stays busy forever.
// - Bit 31 reads 0 while initializing and 1 when power-up is done.
// - Voltage window and HCS are evaluated only at the first ACMD41.
// - After CMD8 the ACMD41 reply carries CCS, valid only when ready.
// - Bit 30 is 1 for high capacity, 0 for standard, after power-up.
// - Incompatible operating conditions send the card to inactive.
// - In ready, CMD2 returns the 128-bit identity, then identification state.
// - CMD3 publishes a new relative address and enters stand-by.
// - Every further CMD3 publishes another address; the last one is active.
// - In stand-by CMD9 with the card's relative address returns the card-specific data.
// - Optional CMD4 programs the driver stage register of identified cards.
// - Registers are reachable only through their commands.
// - Reserved register bits read 0.
// - Bit 7 defaults 0; a dual-voltage card sets it after CMD8.
// - Bits 23 to 15 read 1; bit 24 and the other reserved bits read 0.
// - Widths: identity 128, specific 128, address 16, driver 16, config 64, conditions 32.
// - Relative address resets to 0x0000, the reserved deselect value.
package sdci_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [5:0] CMD_GO_IDLE = 6'h00;
	localparam logic [5:0] CMD_ALL_CID = 6'h02;
	localparam logic [5:0] CMD_SET_RCA = 6'h03;
	localparam logic [5:0] CMD_SET_DSR = 6'h04;
	localparam logic [5:0] CMD_IF_COND = 6'h08;
	localparam logic [5:0] CMD_SEND_CSD = 6'h09;
	localparam logic [5:0] CMD_APP = 6'h37;
	localparam logic [5:0] ACMD_OP_COND = 6'h29;
	localparam logic [5:0] IDX_ALL_ONES = 6'h3F;
	localparam int COND_BUSY = 31;
	localparam int COND_CCS = 30;
	localparam int COND_WIN_HI = 23;
	localparam int COND_WIN_LO = 15;
	localparam int COND_DUAL = 7;
	localparam int ARG_HCS = 30;
	localparam logic [8:0] COND_WINDOW = 9'h1FF;
	localparam logic [3:0] VHS_OK = 4'h1;
	localparam logic [6:0] CRC_POLY = 7'h09;
	localparam logic [6:0] CRC_NONE = 7'h7F;
	localparam logic [5:0] FRAME_LAST = 6'h2F;
	localparam logic [7:0] LEN_SHORT = 8'h30;
	localparam logic [7:0] LEN_LONG = 8'h88;
	localparam logic [1:0] NCR_WAIT = 2'h2;
	localparam logic [15:0] RCA_RESET = 16'h0000;
	localparam logic [15:0] DSR_RESET = 16'h0404;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam int STAT_STATE = 9;
	localparam int STAT_APP = 5;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READY = 3'h1,
		ST_IDENT = 3'h3,
		ST_STBY = 3'h2,
		ST_INACT = 3'h6
	} sdci_state_type;
endpackage

// ==== testbench/sdci_host_model.sv ====
// Host controller model that makes the link clock and drives the command line.
`timescale 1ns/100ps
module sdci_host_model (
	// Link clock and command line
	output logic sd_clk,
	output logic host_oe,
	output logic host_out,
	input wire logic cmd_line
);
	logic run;
	logic [135:0] resp;
	int resp_len;

	// The link clock runs one fixed slow rate and stands still low between transfers.
	initial begin
		sd_clk = 1'b0;
		run = 1'b1;
		host_oe = 1'b0;
		host_out = 1'b1;
		forever begin
			#6;
			if (run || sd_clk) begin
				sd_clk = ~sd_clk;
			end
		end
	end

	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	// Sends one command frame and collects a reply of len bits if a start bit shows.
	task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int len);
		logic [47:0] frame;
		int w;
		frame = {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
		resp = '0;
		resp_len = 0;
		run = 1'b1;
		repeat (8) @(posedge sd_clk);
		for (int i = 47; i >= 0; i--) begin
			host_oe <= 1'b1;
			host_out <= frame[i];
			@(posedge sd_clk);
		end
		host_oe <= 1'b0;
		host_out <= 1'b1;
		for (w = 0; w < 64; w++) begin
			@(negedge sd_clk);
			if (cmd_line === 1'b0) begin
				break;
			end
		end
		if (cmd_line === 1'b0) begin
			for (int i = len - 1; i >= 0; i--) begin
				resp[i] = cmd_line;
				if (i > 0) begin
					@(negedge sd_clk);
				end
			end
			resp_len = len;
		end
		repeat (8) @(posedge sd_clk);
		run = 1'b0;
	endtask
endmodule

// ==== testbench/test_sd_card_init_identification.sv ====
// Self-checking bench for the card initialization and identification logic.
`timescale 1ns/100ps
module test_sd_card_init_identification;
	// Identity and specific data values are arbitrary.
	localparam logic [127:0] CID_V = 128'h0123_4567_89AB_CDEF_0011_2233_4455_6601;
	localparam logic [127:0] CSD_V = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F1;
	logic clk;
	logic rst;
	logic sd_clk;
	logic host_oe;
	logic host_out;
	logic cmd_line;
	logic cmd_out;
	logic cmd_oe;
	logic init_ready;
	logic ident_done;
	logic inactive;
	logic [15:0] rca_a;
	logic [15:0] rca_b;
	int n_fail;
	int num_checks;

	// The command line has a pull-up when nobody drives it.
	assign cmd_line = cmd_oe ? cmd_out : (host_oe ? host_out : 1'b1);

	sdci_core #(.POWERUP_US(1), .CID_VALUE(CID_V), .CSD_VALUE(CSD_V)) sdci_core_inst (
		.clk(clk), .rst(rst), .sd_clk(sd_clk), .cmd_in(cmd_line), .cmd_out(cmd_out),
		.cmd_oe(cmd_oe), .init_ready(init_ready), .ident_done(ident_done), .inactive(inactive)
	);
	sdci_host_model sdci_host_model_inst (
		.sd_clk(sd_clk), .host_oe(host_oe), .host_out(host_out), .cmd_line(cmd_line)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [135:0] exp, input logic [135:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic send(input logic [5:0] idx, input logic [31:0] arg, input int len);
		sdci_host_model_inst.xfer(idx, arg, len);
	endtask

	task automatic acmd41(input logic [31:0] arg);
		send(sdci_pkg::CMD_APP, 32'h0000_0000, 48);
		send(sdci_pkg::ACMD_OP_COND, arg, 48);
	endtask

	task automatic chk_cond(input logic [31:0] exp);
		check("conditions reply", {2'b00, sdci_pkg::IDX_ALL_ONES, exp, sdci_pkg::CRC_NONE, 1'b1},
			sdci_host_model_inst.resp);
	endtask

	task automatic poll_ready;
		for (int i = 0; i < 8 && sdci_host_model_inst.resp[39] !== 1'b1; i++) begin
			acmd41(32'h00FF_8000);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#500_000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		n_fail = 0;
		num_checks = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// ****************************************
		// High-capacity card told HCS is 0 after CMD8.
		// ****************************************
		send(sdci_pkg::CMD_GO_IDLE, 32'h0000_0000, 48);
		check("reset cmd reply", 0, sdci_host_model_inst.resp_len);
		send(sdci_pkg::CMD_IF_COND, 32'h0000_01AA, 48);
		check("cmd8 echo", {2'b00, sdci_pkg::CMD_IF_COND, 32'h0000_01AA},
			sdci_host_model_inst.resp[47:8]);
		for (int i = 0; i < 4; i++) begin
			acmd41(32'h00FF_8000);
			chk_cond(32'h00FF_8080);
		end
		check("init_ready", 0, init_ready);
		$display("Test 1 done");
		// ****************************************
		// HCS 1 at first ACMD41, later ones carry 0.
		// ****************************************
		send(sdci_pkg::CMD_GO_IDLE, 32'h0000_0000, 48);
		send(sdci_pkg::CMD_IF_COND, 32'h0000_01AA, 48);
		acmd41(32'h40FF_8000);
		poll_ready();
		chk_cond(32'hC0FF_8080);
		check("init_ready", 1, init_ready);
		$display("Test 2 done");
		// ****************************************
		// Identity, two addresses, specific data and driver stage.
		// ****************************************
		send(sdci_pkg::CMD_ALL_CID, 32'h0000_0000, 136);
		check("cid reply", {2'b00, 6'h3F, CID_V[127:1], 1'b1}, sdci_host_model_inst.resp);
		send(sdci_pkg::CMD_SET_RCA, 32'h0000_0000, 48);
		rca_a = sdci_host_model_inst.resp[39:24];
		check("rca reply index", {2'b00, sdci_pkg::CMD_SET_RCA},
			sdci_host_model_inst.resp[47:40]);
		check("rca nonzero", 1, rca_a != 16'h0000);
		send(sdci_pkg::CMD_SET_RCA, 32'h0000_0000, 48);
		rca_b = sdci_host_model_inst.resp[39:24];
		check("rca renewed", 1, rca_b != rca_a && rca_b != 16'h0000);
		check("ident_done", 1, ident_done);
		send(sdci_pkg::CMD_SEND_CSD, {rca_a, 16'h0000}, 136);
		check("csd old rca", 0, sdci_host_model_inst.resp_len);
		send(sdci_pkg::CMD_SEND_CSD, {rca_b, 16'h0000}, 136);
		check("csd reply", {2'b00, 6'h3F, CSD_V[127:1], 1'b1}, sdci_host_model_inst.resp);
		send(sdci_pkg::CMD_SET_DSR, 32'h1234_0000, 48);
		check("dsr reply", 0, sdci_host_model_inst.resp_len);
		$display("Test 3 done");
		// ****************************************
		// No CMD8: HCS ignored, capacity and dual bits clear.
		// ****************************************
		send(sdci_pkg::CMD_GO_IDLE, 32'h0000_0000, 48);
		send(sdci_pkg::ACMD_OP_COND, 32'h00FF_8000, 48);
		check("bare acmd41", 0, sdci_host_model_inst.resp_len);
		acmd41(32'h00FF_8000);
		poll_ready();
		chk_cond(32'h80FF_8000);
		$display("Test 4 done");
		// ****************************************
		// Empty voltage window sends the card to inactive.
		// ****************************************
		send(sdci_pkg::CMD_GO_IDLE, 32'h0000_0000, 48);
		acmd41(32'h0000_0000);
		check("inactive reply", 0, sdci_host_model_inst.resp_len);
		check("inactive", 1, inactive);
		send(sdci_pkg::CMD_GO_IDLE, 32'h0000_0000, 48);
		send(sdci_pkg::CMD_IF_COND, 32'h0000_01AA, 48);
		check("inactive cmd8", 0, sdci_host_model_inst.resp_len);
		$display("Test 5 done");
		report_and_stop();
	end
endmodule
